// file: mcpg_chk.sv
// Port checker of the motor PWM generator
`timescale 1ns/100ps
module mcpg_chk (
  input wire logic        MCLK_I,
  input wire logic        RST_N_I,
  input wire logic        CE_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        FLT_A_N_I,
  input wire logic [2:0]  PIN_INIT_CFG_I,
  input wire logic [7:0]  PWM_O,
  input wire logic [7:0]  PWM_OE_O,
  input wire logic        ADC_TRIG_O,
  input wire logic        TB_EVT_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  logic setup;
  assign setup = PSEL_I && !PENABLE_I;
  property p_rdy; PSEL_I && PENABLE_I |-> PREADY_O; endproperty
  a_rdy: assert property (p_rdy) else $error("access without ready");
  property p_bad; setup && (PADDR_I > 8'h3c || PADDR_I[1:0] != 2'h0) |=> PSLVERR_O; endproperty
  a_bad: assert property (p_bad) else $error("unmapped address not refused");
  property p_ok; setup && PADDR_I <= 8'h3c && PADDR_I[1:0] == 2'h0 |=> !PSLVERR_O; endproperty
  a_ok: assert property (p_ok) else $error("mapped address refused");
  property p_bad_rd; setup && !PWRITE_I && PADDR_I > 8'h3c |=> PRDATA_O == 32'h0; endproperty
  a_bad_rd: assert property (p_bad_rd) else $error("unmapped read not zero");
  property p_trig; ADC_TRIG_O |=> !ADC_TRIG_O; endproperty
  a_trig: assert property (p_trig) else $error("trigger pulse too long");
  property p_evt; TB_EVT_O |=> !TB_EVT_O; endproperty
  a_evt: assert property (p_evt) else $error("event pulse too long");
  property p_ce; !CE_I |=> $stable(PWM_O) && $stable(PWM_OE_O); endproperty
  a_ce: assert property (p_ce) else $error("pins moved while frozen");
  property p_rst_oe; disable iff (1'b0)
    $rose(RST_N_I) |-> PWM_OE_O == {8{PIN_INIT_CFG_I[0]}}; endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("reset pin drive wrong");
  property p_rst_lvl; disable iff (1'b0)
    $rose(RST_N_I) |-> PWM_O == {4{PIN_INIT_CFG_I[2], PIN_INIT_CFG_I[1]}}; endproperty
  a_rst_lvl: assert property (p_rst_lvl) else $error("reset pin level wrong");
  property p_rst_rdy; disable iff (1'b0) $rose(RST_N_I) |-> !PREADY_O ##1 PREADY_O; endproperty
  a_rst_rdy: assert property (p_rst_rdy) else $error("ready not up after reset");
  c_err: cover property (setup ##1 PSLVERR_O);
  c_trig: cover property (ADC_TRIG_O);
  c_flt: cover property ($fell(FLT_A_N_I));
endmodule : mcpg_chk
bind mcpg_top mcpg_chk mcpg_chk_i (.MCLK_I, .RST_N_I, .CE_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
  .PADDR_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .FLT_A_N_I, .PIN_INIT_CFG_I, .PWM_O,
  .PWM_OE_O, .ADC_TRIG_O, .TB_EVT_O);

// file: mcpg_deadtime.sv
// Dead-time insertion for one output pair
`timescale 1ns/100ps
module mcpg_deadtime #(
  parameter int W = 10
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire logic         raw_i,
  input  wire logic         indep_i,
  input  wire logic [W-1:0] dt_hi_i,
  input  wire logic [W-1:0] dt_lo_i,
  output logic              hi_o,
  output logic              lo_o
);
  typedef struct packed {
    logic         prev;
    logic [W-1:0] cnt;
    logic         hi;
    logic         lo;
  } mcpg_dt_st_t;
  mcpg_dt_st_t s_r, s_nxt;
  logic [W-1:0] ld;

  always_comb begin
    s_nxt = s_r;
    ld    = raw_i ? dt_hi_i : dt_lo_i;
    if (indep_i) begin
      s_nxt.prev = raw_i;
      s_nxt.cnt  = '0;
      s_nxt.hi   = raw_i;
      s_nxt.lo   = raw_i;
    end else if (raw_i != s_r.prev) begin
      // Both sides off for the dead time of the side turning on
      s_nxt.prev = raw_i;
      // Count from ld-1 so that the off time is exactly ld cycles
      s_nxt.cnt  = (ld == '0) ? '0 : ld - 1'b1;
      s_nxt.hi   = (ld == '0) && raw_i;
      s_nxt.lo   = (ld == '0) && !raw_i;
    end else if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end else begin
      s_nxt.hi = raw_i;
      s_nxt.lo = !raw_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign hi_o = s_r.hi;
  assign lo_o = s_r.lo;
endmodule : mcpg_deadtime

// file: mcpg_defs.svh
// Constants, register map and field positions of the motor PWM generator
`ifndef MCPG_DEFS_SVH
`define MCPG_DEFS_SVH
`define MCPG_A_TCON   8'h00
`define MCPG_A_TMR    8'h04
`define MCPG_A_PER    8'h08
`define MCPG_A_SECMP  8'h0c
`define MCPG_A_PAIR   8'h10
`define MCPG_A_UPD    8'h14
`define MCPG_A_DTSET  8'h18
`define MCPG_A_DTSEL  8'h1c
`define MCPG_A_FLTA   8'h20
`define MCPG_A_FLTB   8'h24
`define MCPG_A_OVD    8'h28
`define MCPG_A_DUTY0  8'h2c
`define MCPG_A_DUTY1  8'h30
`define MCPG_A_DUTY2  8'h34
`define MCPG_A_DUTY3  8'h38
`define MCPG_A_FSTAT  8'h3c
`define MCPG_TC_EN    15
`define MCPG_DIR_BIT  15
`define MCPG_FLT_LAT  7
`define MCPG_PER_RST  15'h0000
`define MCPG_TCY_CLKS 2
`endif

// file: mcpg_pkg.sv
// Types of the motor PWM generator
package mcpg_pkg;
  typedef enum logic [1:0] {MD_FREE, MD_SINGLE, MD_CENTER, MD_DOUBLE} mcpg_mode_t;
  typedef enum logic {CNT_UP, CNT_DOWN} mcpg_dir_t;
endpackage : mcpg_pkg

// file: mcpg_postscale.sv
// Event postscaler: one output pulse every ratio+1 input events
`timescale 1ns/100ps
module mcpg_postscale (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic       evt_i,
  input  wire logic [3:0] ratio_i,
  output logic            pulse_o
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       pulse;
  } mcpg_ps_st_t;
  mcpg_ps_st_t s_r, s_nxt;

  always_comb begin
    s_nxt       = s_r;
    s_nxt.pulse = 1'b0;
    if (evt_i) begin
      if (s_r.cnt >= ratio_i) begin
        s_nxt.cnt   = 4'h0;
        s_nxt.pulse = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign pulse_o = s_r.pulse;
endmodule : mcpg_postscale

// file: mcpg_stage.sv
// Power stage stand-in: drives the two fault lines on request
`timescale 1ns/100ps
module mcpg_stage (
  input  wire logic clk_i,
  input  wire logic fa_req_i,
  input  wire logic fb_req_i,
  output logic      flt_a_n_o,
  output logic      flt_b_n_o
);
  initial begin
    flt_a_n_o = 1'b1;
    flt_b_n_o = 1'b1;
  end
  // Lines move at the edge itself, through nonblocking assignment
  always @(posedge clk_i) begin
    flt_a_n_o <= !fa_req_i;
    flt_b_n_o <= !fb_req_i;
  end
endmodule : mcpg_stage

// file: mcpg_top.sv
// Motor PWM generator: APB registers, time base, duty, override and fault logic
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/100ps
`include "mcpg_defs.svh"
module mcpg_top #(
  parameter int NPAIR = 4,
  parameter int DTW   = 10
) (
  input  wire logic        MCLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        CE_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        FLT_A_N_I,
  input  wire logic        FLT_B_N_I,
  input  wire logic [2:0]  PIN_INIT_CFG_I,
  output logic      [7:0]  PWM_O,
  output logic      [7:0]  PWM_OE_O,
  output logic             ADC_TRIG_O,
  output logic             TB_EVT_O
);
  localparam int NOUT = 2 * NPAIR;

  typedef struct packed {
    logic                        en;
    logic [3:0]                  optps;
    logic [1:0]                  ckps;
    mcpg_pkg::mcpg_mode_t        mode;
    logic [14:0]                 cnt;
    mcpg_pkg::mcpg_dir_t         dir;
    logic [6:0]                  pre;
    logic [14:0]                 per_buf;
    logic [14:0]                 per_act;
    logic [14:0]                 secmp;
    logic                        special_event_direction_select;
    logic [NPAIR-1:0]            indep;
    logic [NOUT-1:0]             pen;
    logic [3:0]                  sevops;
    logic                        iue;
    logic                        osync;
    logic                        udis;
    logic [5:0]                  dta;
    logic [5:0]                  dtb;
    logic [1:0]                  dtpa;
    logic [1:0]                  dtpb;
    logic [NOUT-1:0]             dtsel;
    logic [1:0][NOUT-1:0]        flvl;
    logic [1:0]                  flat;
    logic [1:0][NPAIR-1:0]       fgov;
    logic [1:0]                  fact;
    logic [NOUT-1:0]             ovd_en;
    logic [NOUT-1:0]             ovd_val;
    logic [NOUT-1:0]             ovd_en_a;
    logic [NOUT-1:0]             ovd_val_a;
    logic [NPAIR-1:0][15:0]      dc_buf;
    logic [NPAIR-1:0][15:0]      dc_act;
    logic [NPAIR-1:0]            raw;
    logic                        wrap_d;
    logic [NOUT-1:0]             out;
    logic [NOUT-1:0]             oe;
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
    logic [2:0]                  cfg;
  } mcpg_st_t;

  mcpg_st_t s_r, s_nxt;

  logic             tick, wrap, mid, upd, sev_hit;
  logic [6:0]       lim;
  logic [15:0]      cmpv;
  logic             wr, rd_setup;
  logic [1:0]       flt_in;
  logic [1:0]       fclr;
  logic [NPAIR-1:0] dt_hi, dt_lo;
  logic [DTW-1:0]   dta_cyc, dtb_cyc;
  logic             sev_pulse, tb_pulse;
  logic [NOUT-1:0]  pin;

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux

  function automatic logic [31:0] rd_mux(input mcpg_st_t s, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      `MCPG_A_TCON:  d = {16'h0000, s.en, 7'h00, s.optps, s.ckps, s.mode};
      `MCPG_A_TMR:   d = {16'h0000, (s.dir == mcpg_pkg::CNT_DOWN), s.cnt};
      `MCPG_A_PER:   d = {17'h00000, s.per_buf};
      `MCPG_A_SECMP: d = {16'h0000, s.special_event_direction_select, s.secmp};
      `MCPG_A_PAIR:  d = {20'h00000, s.pen, s.indep};
      `MCPG_A_UPD:   d = {20'h00000, s.sevops, 5'h00, s.iue, s.osync, s.udis};
      `MCPG_A_DTSET: d = {16'h0000, s.dtpb, s.dtb, s.dtpa, s.dta};
      `MCPG_A_DTSEL: d = {24'h000000, s.dtsel};
      `MCPG_A_FLTA:  d = {16'h0000, s.flvl[0], s.flat[0], 3'h0, s.fgov[0]};
      `MCPG_A_FLTB:  d = {16'h0000, s.flvl[1], s.flat[1], 3'h0, s.fgov[1]};
      `MCPG_A_OVD:   d = {16'h0000, s.ovd_en, s.ovd_val};
      `MCPG_A_DUTY0: d = {16'h0000, s.dc_buf[0]};
      `MCPG_A_DUTY1: d = {16'h0000, s.dc_buf[1]};
      `MCPG_A_DUTY2: d = {16'h0000, s.dc_buf[2]};
      `MCPG_A_DUTY3: d = {16'h0000, s.dc_buf[3]};
      `MCPG_A_FSTAT: d = {30'h00000000, s.fact};
      default:       d = 32'h0000_0000;
    endcase
    return d;
  endfunction : rd_mux

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= `MCPG_A_FSTAT);
  endfunction : mapped

  // Dead time in clock cycles: count times prescale times one Tcy
  function automatic logic [DTW-1:0] dt_cycles(input logic [5:0] n, input logic [1:0] p);
    return DTW'({4'h0, n} << ({1'b0, p} + 3'h1));
  endfunction : dt_cycles

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    s_nxt    = s_r;
    wr       = PSEL_I && PENABLE_I && s_r.pready && PWRITE_I;
    rd_setup = PSEL_I && !PENABLE_I;
    flt_in   = {!FLT_B_N_I, !FLT_A_N_I};
    fclr     = 2'h0;
    wrap     = 1'b0;
    mid      = 1'b0;
    // One tick per Tcy times the input prescale (1, 4, 16, 64)
    lim      = 7'((8'd`MCPG_TCY_CLKS << {s_r.ckps, 1'b0}) - 8'd1);
    // Limit met or passed: a smaller prescale written mid-count must not stall
    tick     = s_r.en && (s_r.pre >= lim);

    // APB access
    s_nxt.pready = 1'b1;
    if (rd_setup) begin
      s_nxt.prdata  = rd_mux(s_r, PADDR_I);
      s_nxt.pslverr = !mapped(PADDR_I);
    end

    // Time base
    s_nxt.pre = (!s_r.en || tick) ? 7'h00 : s_r.pre + 7'h01;
    if (tick) begin
      case (s_r.mode)
        mcpg_pkg::MD_FREE, mcpg_pkg::MD_SINGLE: begin
          s_nxt.dir = mcpg_pkg::CNT_UP;
          if (s_r.cnt >= s_r.per_act) begin
            s_nxt.cnt = 15'h0000;
            wrap      = 1'b1;
            if (s_r.mode == mcpg_pkg::MD_SINGLE) begin
              s_nxt.en = 1'b0;
            end
          end else begin
            s_nxt.cnt = s_r.cnt + 15'h0001;
          end
        end
        mcpg_pkg::MD_CENTER, mcpg_pkg::MD_DOUBLE: begin
          if (s_r.dir == mcpg_pkg::CNT_UP) begin
            if (s_r.cnt >= s_r.per_act) begin
              s_nxt.dir = mcpg_pkg::CNT_DOWN;
              s_nxt.cnt = (s_r.cnt == 15'h0000) ? 15'h0000 : s_r.cnt - 15'h0001;
              mid       = 1'b1;
            end else begin
              s_nxt.cnt = s_r.cnt + 15'h0001;
            end
          end else if (s_r.cnt == 15'h0000) begin
            s_nxt.dir = mcpg_pkg::CNT_UP;
            s_nxt.cnt = 15'h0001;
            wrap      = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt - 15'h0001;
          end
        end
        default: s_nxt.cnt = 15'h0000;
      endcase
    end
    upd = wrap || (mid && (s_r.mode == mcpg_pkg::MD_DOUBLE));

    // Special event compare
    sev_hit = tick && (s_r.cnt == s_r.secmp) &&
              ((s_r.mode == mcpg_pkg::MD_FREE) || (s_r.mode == mcpg_pkg::MD_SINGLE) ||
               ((s_r.dir == mcpg_pkg::CNT_DOWN) == s_r.special_event_direction_select));

    // Buffer to active transfers; a stopped time base loads at once
    if (!s_r.udis) begin
      if (upd || !s_r.en) begin
        s_nxt.per_act = s_r.per_buf;
      end
      for (int p = 0; p < NPAIR; p++) begin
        if (upd || s_r.iue || !s_r.en) begin
          s_nxt.dc_act[p] = s_r.dc_buf[p];
        end
      end
    end

    // Duty compare on count plus, at input prescale 1 only, the half-Tcy phase
    cmpv = {s_r.cnt, (s_r.ckps == 2'h0) ? s_r.pre[0] : 1'b0};
    for (int p = 0; p < NPAIR; p++) begin
      s_nxt.raw[p] = s_r.en && (s_r.dc_act[p] > cmpv);
    end
    s_nxt.wrap_d = wrap;

    // Override copies follow the time base only when asked to
    if (!s_r.osync || wrap || !s_r.en) begin
      s_nxt.ovd_en_a  = s_r.ovd_en;
      s_nxt.ovd_val_a = s_r.ovd_val;
    end

    // Register writes
    if (wr) begin
      case (PADDR_I)
        `MCPG_A_TCON: begin
          s_nxt.en    = PWDATA_I[`MCPG_TC_EN];
          s_nxt.optps = PWDATA_I[7:4];
          s_nxt.ckps  = PWDATA_I[3:2];
          s_nxt.mode  = mcpg_pkg::mcpg_mode_t'(PWDATA_I[1:0]);
        end
        `MCPG_A_TMR: begin
          s_nxt.cnt = PWDATA_I[14:0];
          s_nxt.dir = mcpg_pkg::mcpg_dir_t'(PWDATA_I[`MCPG_DIR_BIT]);
        end
        `MCPG_A_PER:   s_nxt.per_buf = PWDATA_I[14:0];
        `MCPG_A_SECMP: begin
          s_nxt.secmp   = PWDATA_I[14:0];
          s_nxt.special_event_direction_select = PWDATA_I[15];
        end
        `MCPG_A_PAIR: begin
          s_nxt.indep = PWDATA_I[3:0];
          s_nxt.pen   = PWDATA_I[11:4];
        end
        `MCPG_A_UPD: begin
          s_nxt.sevops = PWDATA_I[11:8];
          s_nxt.iue    = PWDATA_I[2];
          s_nxt.osync  = PWDATA_I[1];
          s_nxt.udis   = PWDATA_I[0];
        end
        `MCPG_A_DTSET: begin
          s_nxt.dta  = PWDATA_I[5:0];
          s_nxt.dtpa = PWDATA_I[7:6];
          s_nxt.dtb  = PWDATA_I[13:8];
          s_nxt.dtpb = PWDATA_I[15:14];
        end
        `MCPG_A_DTSEL: s_nxt.dtsel = PWDATA_I[7:0];
        `MCPG_A_FLTA: begin
          s_nxt.flvl[0] = PWDATA_I[15:8];
          s_nxt.flat[0] = PWDATA_I[`MCPG_FLT_LAT];
          s_nxt.fgov[0] = PWDATA_I[3:0];
        end
        `MCPG_A_FLTB: begin
          s_nxt.flvl[1] = PWDATA_I[15:8];
          s_nxt.flat[1] = PWDATA_I[`MCPG_FLT_LAT];
          s_nxt.fgov[1] = PWDATA_I[3:0];
        end
        `MCPG_A_OVD: begin
          s_nxt.ovd_en  = PWDATA_I[15:8];
          s_nxt.ovd_val = PWDATA_I[7:0];
        end
        `MCPG_A_DUTY0: s_nxt.dc_buf[0] = PWDATA_I[15:0];
        `MCPG_A_DUTY1: s_nxt.dc_buf[1] = PWDATA_I[15:0];
        `MCPG_A_DUTY2: s_nxt.dc_buf[2] = PWDATA_I[15:0];
        `MCPG_A_DUTY3: s_nxt.dc_buf[3] = PWDATA_I[15:0];
        `MCPG_A_FSTAT: fclr = PWDATA_I[1:0];
        default: ;
      endcase
    end

    // Fault state: an active input always wins over a clear
    for (int f = 0; f < 2; f++) begin
      if (flt_in[f]) begin
        s_nxt.fact[f] = 1'b1;
      end else if (s_r.flat[f] ? fclr[f] : wrap) begin
        s_nxt.fact[f] = 1'b0;
      end
    end

    // Pin chain: dead time, override, fault, polarity, enable
    for (int k = 0; k < NOUT; k++) begin
      pin[k] = k[0] ? dt_lo[k/2] : dt_hi[k/2];
      if (s_r.ovd_en_a[k]) begin
        pin[k] = s_r.ovd_val_a[k];
      end
      if ((s_r.fact[0] || flt_in[0]) && s_r.fgov[0][k/2]) begin
        pin[k] = s_r.flvl[0][k];
      end else if ((s_r.fact[1] || flt_in[1]) && s_r.fgov[1][k/2]) begin
        pin[k] = s_r.flvl[1][k];
      end
      s_nxt.out[k] = pin[k] ^ (k[0] ? s_r.cfg[2] : s_r.cfg[1]);
      s_nxt.oe[k]  = s_r.pen[k];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dead-time units and postscalers

  assign dta_cyc = dt_cycles(s_r.dta, s_r.dtpa);
  assign dtb_cyc = dt_cycles(s_r.dtb, s_r.dtpb);

  generate
    for (genvar p = 0; p < NPAIR; p++) begin : g_pair
      mcpg_deadtime #(
        .W(DTW)
      ) u_dt (
        .clk_i   (MCLK_I),
        .rst_n_i (RST_N_I),
        .ce_i    (CE_I),
        .raw_i   (s_r.raw[p]),
        .indep_i (s_r.indep[p]),
        .dt_hi_i (s_r.dtsel[2*p]   ? dtb_cyc : dta_cyc),
        .dt_lo_i (s_r.dtsel[2*p+1] ? dtb_cyc : dta_cyc),
        .hi_o    (dt_hi[p]),
        .lo_o    (dt_lo[p])
      );
    end
  endgenerate

  mcpg_postscale u_sev_ps (
    .clk_i   (MCLK_I),
    .rst_n_i (RST_N_I),
    .ce_i    (CE_I),
    .evt_i   (sev_hit),
    .ratio_i (s_r.sevops),
    .pulse_o (sev_pulse)
  );

  mcpg_postscale u_tb_ps (
    .clk_i   (MCLK_I),
    .rst_n_i (RST_N_I),
    .ce_i    (CE_I),
    .evt_i   (s_r.wrap_d),
    .ratio_i (s_r.optps),
    .pulse_o (tb_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset pin state taken from the config word

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      s_r        <= '0;
      s_r.cfg    <= PIN_INIT_CFG_I;
      s_r.pen    <= {NOUT{PIN_INIT_CFG_I[0]}};
      s_r.oe     <= {NOUT{PIN_INIT_CFG_I[0]}};
      s_r.out    <= {NPAIR{PIN_INIT_CFG_I[2], PIN_INIT_CFG_I[1]}};
      s_r.per_buf <= `MCPG_PER_RST;
      s_r.per_act <= `MCPG_PER_RST;
    end else if (CE_I) begin
      s_r <= s_nxt;
    end
  end

  assign PRDATA_O   = s_r.prdata;
  assign PREADY_O   = s_r.pready;
  assign PSLVERR_O  = s_r.pslverr;
  assign PWM_O      = s_r.out;
  assign PWM_OE_O   = s_r.oe;
  assign ADC_TRIG_O = sev_pulse;
  assign TB_EVT_O   = tb_pulse;
endmodule : mcpg_top

// file: tb_motor_control_pwm_generator.sv
// Self-checking bench of the motor PWM generator
`timescale 1ns/100ps
module tb_motor_control_pwm_generator;
  logic        clk = 0, rst_n = 0, ce = 1, psel = 0, pen = 0, pwr = 0;
  logic [7:0]  paddr = 8'h00, pwm, oe;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h3c50;
  logic        pready, pslverr, adc, evt, err, fa_n, fb_n, dseen;
  logic        fa_req = 0, fb_req = 0;
  logic [2:0]  cfg = 3'b011;
  int          n_mismatch = 0, n_checks = 0, h, l, g;
  int          mdl [int];
  logic [7:0]  ra [6] = '{8'h08, 8'h0c, 8'h18, 8'h1c, 8'h2c, 8'h38};
  logic [31:0] rm [6] = '{32'h7fff, 32'hffff, 32'hffff, 32'h00ff, 32'hffff, 32'hffff};
  // Duty table: duty, dead setup, unit select
  int          td [5] = '{0, 11, 20, 10, 10};
  int          tt [5] = '{0, 0, 0, 32'h0002, 32'h4100};
  int          ts [5] = '{0, 0, 0, 0, 3};
  mcpg_top mcpg_top_i (.MCLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .FLT_A_N_I(fa_n), .FLT_B_N_I(fb_n),
    .PIN_INIT_CFG_I(cfg), .PWM_O(pwm), .PWM_OE_O(oe), .ADC_TRIG_O(adc), .TB_EVT_O(evt));
  mcpg_stage mcpg_stage_i (.clk_i(clk), .fa_req_i(fa_req), .fb_req_i(fb_req),
    .flt_a_n_o(fa_n), .flt_b_n_o(fb_n));
  initial forever #20 clk = !clk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Answer taken at the edge that sees ready high; the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    mdl[a] = d;
  endtask : wr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic act(input int n);
    h = 0;
    l = 0;
    repeat (n) begin
      @(negedge clk);
      h += (pwm[0] === 1'b0);
      l += (pwm[1] === 1'b1);
    end
  endtask : act
  task automatic gap(input bit s);
    g = 0;
    for (int i = 0; i < 2000 && (s ? adc : evt) !== 1'b1; i++) @(negedge clk);
    do begin
      @(negedge clk);
      g++;
    end while ((s ? adc : evt) !== 1'b1 && g < 2000);
  endtask : gap
  task automatic end_of_test;
    $display("TB: checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test;
  end
  initial begin
    int dd, hi, lo;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(oe, 8'hff);
    chk(pwm, 8'h55);
    foreach (ra[i]) begin
      wr(ra[i], xs() & rm[i]);
      apb(1'b0, ra[i], 32'h0);
      chk(rd, mdl[ra[i]]);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h40, xs());
    chk(err, 1'b1);
    $display("TB: registers done");
    wr(8'h08, 32'd5);
    foreach (rm[i]) if (i < 3) begin
      wr(8'h00, 32'h8000 | ((i * 2 - (i > 1)) << 4));
      gap(0);
      chk(g, 12 * (i * 2 - (i > 1) + 1));
    end
    wr(8'h00, 32'h8000);
    wr(8'h08, 32'd9);
    gap(0);
    gap(0);
    chk(g, 20);
    wr(8'h00, 32'h8004);
    gap(0);
    gap(0);
    chk(g, 80);
    wr(8'h00, 32'h8000);
    wr(8'h0c, 32'd3);
    for (int u = 0; u < 3; u += 2) begin
      wr(8'h14, u << 8);
      gap(1);
      chk(g, 20 * (u + 1));
    end
    $display("TB: events done");
    for (int m = 0; m < 4; m++) if (m != 1) begin
      wr(8'h00, 32'h8000 | m);
      dseen = 1'b0;
      repeat (30) begin
        apb(1'b0, 8'h04, 32'h0);
        dseen |= rd[15];
        chk(rd[14:0] <= 15'd9, 1'b1);
      end
      chk(dseen, m != 0);
    end
    wr(8'h00, 32'h8001);
    repeat (60) @(posedge clk);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd[15], 1'b0);
    apb(1'b0, 8'h04, 32'h0);
    g = rd;
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, g);
    $display("TB: modes done");
    wr(8'h00, 32'h8000);
    wr(8'h14, 32'h4);
    wr(8'h10, 32'hff0);
    foreach (td[i]) begin
      wr(8'h18, tt[i]);
      wr(8'h1c, ts[i]);
      wr(8'h2c, td[i]);
      repeat (60) @(posedge clk);
      act(20);
      // Bench model: each on-going side waits the dead time of the unit that select bit 0 picks
      dd = ts[i][0] ? tt[i] >> 8 : tt[i];
      dd = (dd & 32'h3f) << ((dd >> 6 & 3) + 1);
      hi = td[i] > dd ? td[i] - dd : 0;
      lo = 20 - td[i] > dd ? 20 - td[i] - dd : 0;
      chk(h, hi);
      chk(l, lo);
    end
    wr(8'h10, 32'hff1);
    wr(8'h18, 32'h0);
    wr(8'h2c, 32'd11);
    repeat (60) @(posedge clk);
    act(20);
    chk(h, 11);
    chk(l, 11);
    wr(8'h14, 32'h1);
    wr(8'h2c, 32'd4);
    repeat (60) @(posedge clk);
    act(20);
    chk(h, 11);
    wr(8'h14, 32'h0);
    repeat (60) @(posedge clk);
    act(20);
    chk(h, 4);
    wr(8'h10, 32'h0f0);
    repeat (4) @(posedge clk);
    chk(oe, 8'h0f);
    wr(8'h10, 32'hff0);
    wr(8'h28, 32'h0c0c);
    repeat (6) @(posedge clk);
    chk(pwm[3:2], 2'b10);
    wr(8'h28, 32'h0);
    $display("TB: outputs done");
    wr(8'h20, 32'h0381);
    fa_req <= 1'b1;
    repeat (4) @(negedge clk);
    chk(pwm[1:0], 2'b10);
    fa_req <= 1'b0;
    repeat (50) @(posedge clk);
    chk(pwm[1:0], 2'b10);
    apb(1'b0, 8'h3c, 32'h0);
    chk(rd[1:0], 2'b01);
    wr(8'h3c, 32'h1);
    apb(1'b0, 8'h3c, 32'h0);
    chk(rd[1:0], 2'b00);
    wr(8'h24, 32'h0c02);
    fb_req <= 1'b1;
    repeat (4) @(negedge clk);
    chk(pwm[3:2], 2'b10);
    fb_req <= 1'b0;
    repeat (50) @(negedge clk);
    chk(pwm[3:2], 2'b11);
    @(posedge clk);
    ce <= 1'b0;
    repeat (5) @(posedge clk);
    ce <= 1'b1;
    $display("TB: faults done");
    // Second reset: other polarity, pins not driven
    @(posedge clk);
    cfg <= 3'b100;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(oe, 8'h00);
    chk(pwm, 8'haa);
    $display("TB: reset done");
    end_of_test;
  end
endmodule : tb_motor_control_pwm_generator
